// ### hdl/tfc_params.svh
`ifndef TFC_PARAMS_SVH
`define TFC_PARAMS_SVH
`define TFC_HDR_W 8
`define TFC_DAT_W 12
`define TFC_NARROW_W 22
`define TFC_WIDE_W 66
`define TFC_DAT_CAP 9'h100
`define TFC_HDR_MAX 8'hFF
`define TFC_DAT_MAX 12'hFFF
`define TFC_N_PH 0
`define TFC_N_PD 1
`define TFC_N_NPH 10
`define TFC_N_NPD 11
`define TFC_N_CPLH 12
`define TFC_N_CPLD 13
`define TFC_N_FLD 9
`endif

// ### hdl/tfc_pkg.sv
package tfc_pkg;
	typedef enum logic [1:0] {
		TFC_POSTED,
		TFC_NONPOSTED,
		TFC_COMPLETION
	} tfc_kind_t;

	// Available credits of one virtual channel.
	typedef struct packed {
		logic [7:0] ph;
		logic [11:0] pd;
		logic [7:0] nph;
		logic [11:0] npd;
		logic [7:0] cplh;
		logic [11:0] cpld;
	} tfc_cred_t;
endpackage

// ### hdl/tfc_vc_if.sv
`timescale 1ns/1ps
// Request and credit signals of one virtual channel between top and counter.
interface tfc_vc_if;
	import tfc_pkg::*;
	logic init;
	logic infinite;
	tfc_cred_t init_cred;
	logic update;
	tfc_cred_t update_cred;
	logic req;
	tfc_kind_t kind;
	logic [11:0] dat_need;
	logic ack;
	tfc_cred_t avail;

	modport counter (
		input init, infinite, init_cred, update, update_cred, req, kind, dat_need,
		output ack, avail
	);
	modport top (
		output init, infinite, init_cred, update, update_cred, req, kind, dat_need,
		input ack, avail
	);
endinterface

// ### hdl/tfc_vc_counter.sv
`timescale 1ns/1ps
`include "tfc_params.svh"
// Credit pool of one virtual channel with the acknowledge gate.
module tfc_vc_counter
	import tfc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	tfc_vc_if.counter vc
);
	tfc_cred_t avail_q, avail_d;
	logic inf_q, inf_d;
	logic ack_q, ack_d;
	logic ok;

	// Checks whether the pool covers one header plus the data need of the request.
	always_comb begin
		case (vc.kind)
			TFC_POSTED: ok = inf_q || (avail_q.ph != '0 && avail_q.pd >= vc.dat_need);
			TFC_NONPOSTED: ok = inf_q || (avail_q.nph != '0 && avail_q.npd >= vc.dat_need);
			TFC_COMPLETION: ok = inf_q || (avail_q.cplh != '0 && avail_q.cpld >= vc.dat_need);
			default: ok = 1'b0;
		endcase
	end

	// Computes next pool: init, partner returns, then deduction on acknowledge.
	always_comb begin
		avail_d = avail_q;
		inf_d = inf_q;
		// The own pending acknowledge masks the request so that one request is never taken twice.
		ack_d = vc.req && ok && !vc.init && !ack_q;
		if (vc.init) begin
			avail_d = vc.init_cred;
			inf_d = vc.infinite;
		end else begin
			if (vc.update) begin
				avail_d = vc.update_cred;
			end
			if (ack_d && !inf_q) begin
				case (vc.kind)
					TFC_POSTED: begin
						avail_d.ph = avail_d.ph - 8'h01;
						avail_d.pd = avail_d.pd - vc.dat_need;
					end
					TFC_NONPOSTED: begin
						avail_d.nph = avail_d.nph - 8'h01;
						avail_d.npd = avail_d.npd - vc.dat_need;
					end
					TFC_COMPLETION: begin
						avail_d.cplh = avail_d.cplh - 8'h01;
						avail_d.cpld = avail_d.cpld - vc.dat_need;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Registers the pool; reset empties it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avail_q <= '0;
			inf_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			avail_q <= avail_d;
			inf_q <= inf_d;
			ack_q <= ack_d;
		end
	end

	assign vc.ack = ack_q;
	assign vc.avail = inf_q ? '1 : avail_q;
endmodule

// ### hdl/tfc_credit_report.sv
`timescale 1ns/1ps
`include "tfc_params.svh"
// Transmit credit report for all virtual channels.
module tfc_credit_report
	import tfc_pkg::*;
#(
	parameter int WIDE = 0,
	parameter int NUM_VC = (WIDE != 0) ? 2 : 4,
	parameter int CW = (WIDE != 0) ? `TFC_WIDE_W : `TFC_NARROW_W
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic [NUM_VC-1:0] cred_init,
	input wire logic [NUM_VC-1:0] cred_infinite,
	input wire tfc_cred_t [NUM_VC-1:0] cred_init_val,
	input wire logic [NUM_VC-1:0] cred_update,
	input wire tfc_cred_t [NUM_VC-1:0] cred_update_val,
	input wire logic [NUM_VC-1:0] tx_req,
	input wire tfc_kind_t [NUM_VC-1:0] tx_kind,
	input wire logic [NUM_VC-1:0][11:0] tx_dat_need,
	output logic [NUM_VC-1:0] tx_ack,
	output logic [NUM_VC-1:0][CW-1:0] tx_cred
);
	// ==========================================================
	// Configuration check
	initial begin
		if ((WIDE != 0 && (NUM_VC != 2 || CW != `TFC_WIDE_W)) ||
			(WIDE == 0 && (NUM_VC != 4 || CW != `TFC_NARROW_W))) begin
			$error("Unsupported credit report configuration.");
		end
	end

	// Clamps a data count to the 9-bit field, 0 to 256 credits.
	function automatic logic [8:0] clamp_dat(input logic [11:0] d);
		clamp_dat = (d > 12'(`TFC_DAT_CAP)) ? `TFC_DAT_CAP : d[8:0];
	endfunction

	// Encodes a pool into the narrow or wide credit word.
	function automatic logic [CW-1:0] encode(input tfc_cred_t c, input logic inf);
		logic [`TFC_WIDE_W-1:0] w;
		w = '0;
		if (WIDE != 0) begin
			w = {c.cpld, c.cplh, c.npd, c.nph, c.pd, c.ph, 6'h00};
			if (inf) begin
				w = '1;
			end
		end else begin
			w[`TFC_N_PH] = c.ph != '0;
			w[`TFC_N_PD +: `TFC_N_FLD] = clamp_dat(c.pd);
			w[`TFC_N_NPH] = c.nph != '0;
			w[`TFC_N_NPD] = c.npd != '0;
			w[`TFC_N_CPLH] = c.cplh != '0;
			w[`TFC_N_CPLD +: `TFC_N_FLD] = clamp_dat(c.cpld);
			if (inf) begin
				w[`TFC_NARROW_W-1:0] = '1;
			end
		end
		encode = w[CW-1:0];
	endfunction

	logic [NUM_VC-1:0] ack_d;
	logic [NUM_VC-1:0][CW-1:0] cred_d;
	logic [NUM_VC-1:0] ack_q;
	logic [NUM_VC-1:0][CW-1:0] cred_p;
	logic [NUM_VC-1:0][CW-1:0] cred_q;

	// ==========================================================
	// Per virtual channel pools
	for (genvar v = 0; v < NUM_VC; v++) begin : g_vc
		tfc_vc_if vi();
		assign vi.init = cred_init[v];
		assign vi.infinite = cred_infinite[v];
		assign vi.init_cred = cred_init_val[v];
		assign vi.update = cred_update[v];
		assign vi.update_cred = cred_update_val[v];
		assign vi.req = tx_req[v] && !ack_q[v];
		assign vi.kind = tx_kind[v];
		assign vi.dat_need = tx_dat_need[v];
		tfc_vc_counter u_cnt (
			.clk(clk),
			.rst(rst),
			.vc(vi.counter)
		);
		// Forms the reported word from the pool after the deduction.
		always_comb begin
			ack_d[v] = vi.ack;
			cred_d[v] = encode(vi.avail, vi.avail == '1);
		end
	end

	// Registers the outputs; the extra word stage puts the deduction one clock after the acknowledge.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_q <= '0;
			cred_p <= '0;
			cred_q <= '0;
		end else begin
			ack_q <= ack_d;
			cred_p <= cred_d;
			cred_q <= cred_p;
		end
	end

	assign tx_ack = ack_q;
	assign tx_cred = cred_q;
endmodule

// ### verif/tfc_credit_report_chk.sv
`timescale 1ns/1ps
// ====
// Port checks on the credit report.
module tfc_credit_report_chk
	import tfc_pkg::*;
#(parameter int NUM_VC = 4, parameter int CW = 22)(
	input wire logic clk,
	input wire logic rst,
	input wire logic [NUM_VC-1:0] cred_init,
	input wire logic [NUM_VC-1:0] cred_infinite,
	input wire tfc_cred_t [NUM_VC-1:0] cred_init_val,
	input wire logic [NUM_VC-1:0] cred_update,
	input wire tfc_cred_t [NUM_VC-1:0] cred_update_val,
	input wire logic [NUM_VC-1:0] tx_req,
	input wire tfc_kind_t [NUM_VC-1:0] tx_kind,
	input wire logic [NUM_VC-1:0][11:0] tx_dat_need,
	input wire logic [NUM_VC-1:0] tx_ack,
	input wire logic [NUM_VC-1:0][CW-1:0] tx_cred
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_reset_clear: assert property ($fell(rst) |-> tx_cred == '0 && tx_ack == '0) else $error("not clear");
	a_ack_single: assert property (tx_ack[0] |=> !tx_ack[0]) else $error("long ack");
	a_ack_has_req: assert property (tx_ack[0] |-> $past(tx_req[0], 2)) else $error("ack without request");
	a_ack_had_cred: assert property (tx_ack[0] && $past(tx_kind[0], 2) == TFC_POSTED |-> tx_cred[0][0])
		else $error("ack without header");
	a_hdr_gate: assert property ((!tx_cred[0][0] && tx_kind[0] == TFC_POSTED && !cred_init[0] && !cred_update[0])[*3]
		|-> !tx_ack[0]) else $error("ack with no header");
	a_deduct_next: assert property (tx_ack[0] && tx_cred[0][9:1] < 9'h100 && $past(tx_dat_need[0], 2) != 0
		&& $past(tx_kind[0], 2) == TFC_POSTED |=> tx_cred[0][9:1] < $past(tx_cred[0][9:1])) else $error("no deduct");
	a_inf_max: assert property (cred_init[1] && cred_infinite[1] |-> ##[1:3] &tx_cred[1]) else $error("not max");
	a_pd_range: assert property (!(&tx_cred[0]) |-> tx_cred[0][9:1] <= 9'h100) else $error("pd reserved");
	a_quiet_stable: assert property ((!tx_ack[0] && !cred_init[0] && !cred_update[0])[*3]
		|=> $stable(tx_cred[0])) else $error("word moved");
	c_ack: cover property (tx_ack[0]);
	c_inf: cover property (&tx_cred[1]);
	c_wait: cover property (tx_req[0] && !tx_cred[0][0]);
endmodule
bind tfc_credit_report tfc_credit_report_chk #(.NUM_VC(NUM_VC), .CW(CW)) chk_u (.*);

// ### verif/tfc_app_model.sv
`timescale 1ns/1ps
// ====
// Application side of one channel.
module tfc_app_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic tx_ack,
	output logic tx_req
);
	// The request is held until its acknowledge edge; the credit word is never consulted.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			tx_req <= 1'b0;
		else
			tx_req <= go | (tx_req & ~tx_ack);
	end
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
// ====
// Self-checking bench for the credit report.
module testbench;
	import tfc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] ini = '0, inf = '0, upd = '0, go = '0, req, ack;
	tfc_cred_t [3:0] ival = '0, uval = '0;
	tfc_kind_t [3:0] kind = {4{TFC_POSTED}};
	logic [3:0][11:0] need = '0;
	logic [3:0][21:0] cred;
	int errors = 0;
	int total_checks = 0;
	// Clock and instances.
	always #5 clk = ~clk;
	tfc_credit_report dut_u (.clk(clk), .rst(rst), .cred_init(ini), .cred_infinite(inf), .cred_init_val(ival),
		.cred_update(upd), .cred_update_val(uval), .tx_req(req), .tx_kind(kind), .tx_dat_need(need), .tx_ack(ack),
		.tx_cred(cred));
	tfc_app_model app_u[3:0] (.clk(clk), .rst(rst), .go(go), .tx_ack(ack), .tx_req(req));
	task automatic results();
		$display("errors %0d checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(string what, logic [87:0] exp, logic [87:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Loads or returns credits on one channel and lets the word settle.
	task automatic load(int v, tfc_cred_t c, logic f, logic u);
		@(posedge clk);
		ival[v] <= c;
		uval[v] <= c;
		inf[v] <= f;
		ini[v] <= !u;
		upd[v] <= u;
		@(posedge clk);
		ini[v] <= 1'b0;
		upd[v] <= 1'b0;
		repeat (3) @(negedge clk);
	endtask
	// Raises a request if asked, waits a bounded time for the acknowledge, then one cycle more.
	task automatic send(int v, tfc_kind_t k, logic [11:0] n, logic e, logic f);
		int i;
		if (f) begin
			@(posedge clk);
			kind[v] <= k;
			need[v] <= n;
			go[v] <= 1'b1;
			@(posedge clk);
			go[v] <= 1'b0;
		end
		for (i = 0; i < 9 && ack[v] !== 1'b1; i++)
			@(negedge clk);
		check("ack", e, ack[v]);
		if (e && ack[v] !== 1'b1)
			results();
		@(negedge clk);
	endtask
	// Main sequence.
	initial begin
		repeat (5) @(posedge clk);
		check("reset", 0, cred);
		rst <= 1'b0;
		load(0, {8'h02, 12'h12C, 8'h00, 12'h005, 8'h01, 12'h00A}, 1'b0, 1'b0);
		check("encode", {9'h00A, 3'b110, 9'h100, 1'b1}, cred[0]);
		send(0, TFC_POSTED, 12'h03C, 1'b1, 1'b1);
		check("deduct", {9'h00A, 3'b110, 9'h0F0, 1'b1}, cred[0]);
		send(0, TFC_POSTED, 12'h010, 1'b1, 1'b1);
		check("last header", {9'h00A, 3'b110, 9'h0E0, 1'b0}, cred[0]);
		send(0, TFC_POSTED, 12'h001, 1'b0, 1'b1);
		load(0, {8'h01, 12'h020, 40'h0}, 1'b0, 1'b1);
		send(0, TFC_POSTED, 12'h001, 1'b1, 1'b0);
		check("returned", {9'h000, 3'b000, 9'h01F, 1'b0}, cred[0]);
		load(1, '0, 1'b1, 1'b0);
		load(2, {8'h00, 12'h001, 8'h01, 20'h0, 12'h101}, 1'b0, 1'b0);
		check("vc1", 22'h3FFFFF, cred[1]);
		check("vc2", {9'h100, 3'b001, 9'h001, 1'b0}, cred[2]);
		send(2, TFC_NONPOSTED, 12'h000, 1'b1, 1'b1);
		check("vc2 used", {9'h100, 3'b000, 9'h001, 1'b0}, cred[2]);
		send(1, TFC_COMPLETION, 12'hFFF, 1'b1, 1'b1);
		check("vc1 held", 22'h3FFFFF, cred[1]);
		load(3, {8'h05, 32'h0, 8'h01, 12'h000}, 1'b0, 1'b0);
		check("vc3", {9'h000, 3'b100, 9'h000, 1'b1}, cred[3]);
		results();
	end
endmodule
